// ### verilog/bfq_pkg.sv
/*
  Shared constants for the two-way queue port block: data width, queue depth,
  occupancy width and flag levels after reset.
  Assumes every user of it runs on the one block clock.
*/
package bfq_pkg;
  localparam int DATA_W = 36;
  localparam int QDEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] QDEPTH_CNT = 4'h8;
  localparam logic RST_EMPTY_OR_READY = 1'h0;
  localparam logic RST_FULL_OR_SPACE = 1'h0;
  localparam logic RST_ALMOST_EMPTY = 1'h0;
  localparam logic RST_ALMOST_FULL = 1'h1;
  localparam logic RST_MAIL_FLAG_N = 1'h1;
  localparam logic [DATA_W-1:0] RST_WORD = 36'h0;
endpackage : bfq_pkg

// ### verilog/bfq_fifo_if.sv
/*
  Valid/ready carrier between the port logic and one queue.
  Assumes both ends share one clock.
*/
interface bfq_fifo_if #(
  parameter int WIDTH = 36,
  parameter int CW = 4
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [CW-1:0] count;

  modport fifo (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, count
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, count
  );
endinterface : bfq_fifo_if

// ### verilog/bfq_fifo.sv
/*
  Flip-flop queue with valid/ready on both sides and an occupancy count.
  Assumes one clock and an asynchronous active-high reset.
*/
module bfq_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8,
  parameter int CW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Queue port
  bfq_fifo_if.fifo q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } bfq_fifo_st_t;

  bfq_fifo_st_t st_reg;
  bfq_fifo_st_t st_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bfq_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      bfq_inc = '0;
    end else begin
      bfq_inc = p + AW'(1);
    end
  endfunction : bfq_inc

  assign q.in_ready = (st_reg.cnt != CW'(DEPTH));
  assign q.out_valid = (st_reg.cnt != '0);
  assign q.out_data = st_reg.mem[st_reg.rd];
  assign q.count = st_reg.cnt;
  assign push = q.in_valid & q.in_ready;
  assign pop = q.out_ready & q.out_valid;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = q.in_data;
      st_next.wr = bfq_inc(st_reg.wr);
    end
    if (pop) begin
      st_next.rd = bfq_inc(st_reg.rd);
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : bfq_fifo

// ### verilog/bfq_bidir_port.sv
/*
  Two-way queue device: port A writes into the A-to-B queue and reads the
  B-to-A queue, port B the reverse, each with a mailbox word as bypass.
  Standard or fall-through timing, full/empty and programmable almost flags.
  Assumes port clocks and controls are synchronous levels sampled on mclk;
  a port acts on the mclk cycle in which its port clock is seen rising.
*/
// Summary of operation
// [R1] Port A almost-empty low when B-to-A count<=offset
// [R2] Port B almost-empty low when A-to-B count<=offset
// [R3] Port A almost-full low when A-to-B free<=offset
// [R4] Port B almost-full low when B-to-A free<=offset
// [R5] Each port has 36-bit two-way data
// [R6] Mode sampled at reset: high standard, low fall-through
// [R7] Controller holds mode input steady afterwards
// [R8] Port A acts only on its clock rise; fall-through refills its output stage on any mclk edge
// [R9] Port B acts only on its clock rise; fall-through refills its output stage on any mclk edge
// [R10] Transfers need active-low select asserted
// [R11] Deselected port data outputs are released
// [R12] Transfers need enable high
// [R13] Port A empty/ready per mode, B-to-A queue
// [R14] Port B empty/ready per mode, A-to-B queue
// [R15] Port A full/space per mode, A-to-B queue
// [R16] Port B full/space per mode, B-to-A queue
// [R17] Direction: A high writes, B low writes
// [R18] Mailbox select steers between queue and mailbox
// [R19] Flags are active low when condition holds
module bfq_bidir_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Mode strap
  input wire logic timing_mode_select,
  // Port A control
  input wire logic porta_clock,
  input wire logic porta_select_n,
  input wire logic porta_enable,
  input wire logic porta_direction,
  input wire logic porta_mailbox_select,
  // Port A data pins
  input wire logic [bfq_pkg::DATA_W-1:0] porta_data_in,
  output logic [bfq_pkg::DATA_W-1:0] porta_data_out,
  output logic porta_data_oe,
  // Port A flags
  output logic porta_empty_or_ready,
  output logic porta_full_or_space,
  output logic porta_almost_empty,
  output logic porta_almost_full,
  // Port B control
  input wire logic portb_clock,
  input wire logic portb_select_n,
  input wire logic portb_enable,
  input wire logic portb_direction,
  input wire logic portb_mailbox_select,
  // Port B data pins
  input wire logic [bfq_pkg::DATA_W-1:0] portb_data_in,
  output logic [bfq_pkg::DATA_W-1:0] portb_data_out,
  output logic portb_data_oe,
  // Port B flags
  output logic portb_empty_or_ready,
  output logic portb_full_or_space,
  output logic portb_almost_empty,
  output logic portb_almost_full,
  // Almost-flag offsets
  input wire logic [bfq_pkg::CNT_W-1:0] a2b_empty_offset,
  input wire logic [bfq_pkg::CNT_W-1:0] b2a_empty_offset,
  input wire logic [bfq_pkg::CNT_W-1:0] a2b_full_offset,
  input wire logic [bfq_pkg::CNT_W-1:0] b2a_full_offset,
  // Mailbox flags, low while a word waits
  output logic mail_a2b_flag_n,
  output logic mail_b2a_flag_n
);
  import bfq_pkg::*;

  typedef struct packed {
    logic mode_taken;
    logic fwft;
    logic a_clk_prev;
    logic b_clk_prev;
    logic a_stage_valid;
    logic b_stage_valid;
    logic [DATA_W-1:0] a_stage;
    logic [DATA_W-1:0] b_stage;
    logic a_view_mail;
    logic b_view_mail;
    logic [DATA_W-1:0] a_mail_out;
    logic [DATA_W-1:0] b_mail_out;
    logic [DATA_W-1:0] mail_a2b;
    logic [DATA_W-1:0] mail_b2a;
    logic mail_a2b_n;
    logic mail_b2a_n;
    logic a_eor;
    logic a_fos;
    logic a_ae;
    logic a_af;
    logic b_eor;
    logic b_fos;
    logic b_ae;
    logic b_af;
  } bfq_top_st_t;

  localparam bfq_top_st_t ST_RESET = '{
    mode_taken: 1'h0, fwft: 1'h0, a_clk_prev: 1'h0, b_clk_prev: 1'h0,
    a_stage_valid: 1'h0, b_stage_valid: 1'h0,
    a_stage: RST_WORD, b_stage: RST_WORD,
    a_view_mail: 1'h0, b_view_mail: 1'h0,
    a_mail_out: RST_WORD, b_mail_out: RST_WORD,
    mail_a2b: RST_WORD, mail_b2a: RST_WORD,
    mail_a2b_n: RST_MAIL_FLAG_N, mail_b2a_n: RST_MAIL_FLAG_N,
    a_eor: RST_EMPTY_OR_READY, a_fos: RST_FULL_OR_SPACE,
    a_ae: RST_ALMOST_EMPTY, a_af: RST_ALMOST_FULL,
    b_eor: RST_EMPTY_OR_READY, b_fos: RST_FULL_OR_SPACE,
    b_ae: RST_ALMOST_EMPTY, b_af: RST_ALMOST_FULL
  };

  bfq_top_st_t st_reg;
  bfq_top_st_t st_next;

  bfq_fifo_if #(.WIDTH(DATA_W), .CW(CNT_W)) a_to_b_queue ();
  bfq_fifo_if #(.WIDTH(DATA_W), .CW(CNT_W)) b_to_a_queue ();

  bfq_fifo #(.WIDTH(DATA_W), .DEPTH(QDEPTH), .CW(CNT_W)) u_a_to_b (
    .clk(mclk),
    .rst(rst),
    .q(a_to_b_queue.fifo)
  );

  bfq_fifo #(.WIDTH(DATA_W), .DEPTH(QDEPTH), .CW(CNT_W)) u_b_to_a (
    .clk(mclk),
    .rst(rst),
    .q(b_to_a_queue.fifo)
  );

  // Port access qualifier: clock rise, selected, enabled
  function automatic logic bfq_port_go(input logic rise, input logic sel_n,
                                       input logic en);
    bfq_port_go = rise & ~sel_n & en;
  endfunction : bfq_port_go

  // Flag condition: value at or below offset
  function automatic logic bfq_at_or_below(input logic [CNT_W-1:0] val,
                                           input logic [CNT_W-1:0] off);
    bfq_at_or_below = (val <= off);
  endfunction : bfq_at_or_below

  logic a_rise;
  logic b_rise;
  logic a_go;
  logic b_go;
  logic a_wr;
  logic a_rd;
  logic b_wr;
  logic b_rd;
  logic a_rd_queue;
  logic b_rd_queue;
  logic a_pop;
  logic b_pop;
  logic [CNT_W-1:0] a_occ;
  logic [CNT_W-1:0] b_occ;
  logic [CNT_W-1:0] a2b_free;
  logic [CNT_W-1:0] b2a_free;

  assign a_rise = porta_clock & ~st_reg.a_clk_prev; // [R8]
  assign b_rise = portb_clock & ~st_reg.b_clk_prev; // [R9]
  // Nothing moves before the mode has been taken
  assign a_go = st_reg.mode_taken & bfq_port_go(a_rise, porta_select_n, porta_enable); // [R10] [R12]
  assign b_go = st_reg.mode_taken & bfq_port_go(b_rise, portb_select_n, portb_enable); // [R10] [R12]
  assign a_wr = a_go & porta_direction; // [R17]
  assign a_rd = a_go & ~porta_direction; // [R17]
  assign b_wr = b_go & ~portb_direction; // [R17]
  assign b_rd = b_go & portb_direction; // [R17]
  assign a_rd_queue = a_rd & ~porta_mailbox_select; // [R18]
  assign b_rd_queue = b_rd & ~portb_mailbox_select;

  // Writes into the queues; a write to a full queue is dropped
  assign a_to_b_queue.in_valid = a_wr & ~porta_mailbox_select; // [R18]
  assign a_to_b_queue.in_data = porta_data_in; // [R5]
  assign b_to_a_queue.in_valid = b_wr & ~portb_mailbox_select;
  assign b_to_a_queue.in_data = portb_data_in; // [R5]

  // Pops: standard on a read, fall-through refills the output stage
  always_comb begin
    if (st_reg.fwft) begin
      a_pop = b_to_a_queue.out_valid & (~st_reg.a_stage_valid | a_rd_queue);
      b_pop = a_to_b_queue.out_valid & (~st_reg.b_stage_valid | b_rd_queue);
    end else begin
      a_pop = b_to_a_queue.out_valid & a_rd_queue;
      b_pop = a_to_b_queue.out_valid & b_rd_queue;
    end
  end

  assign b_to_a_queue.out_ready = a_pop;
  assign a_to_b_queue.out_ready = b_pop;

  // Occupancy seen by each reader includes a held fall-through word
  assign a_occ = b_to_a_queue.count + CNT_W'(st_reg.fwft & st_reg.a_stage_valid);
  assign b_occ = a_to_b_queue.count + CNT_W'(st_reg.fwft & st_reg.b_stage_valid);
  assign a2b_free = QDEPTH_CNT - a_to_b_queue.count;
  assign b2a_free = QDEPTH_CNT - b_to_a_queue.count;

  always_comb begin
    st_next = st_reg;
    st_next.a_clk_prev = porta_clock;
    st_next.b_clk_prev = portb_clock;

    // Strap caught on the first edge after reset release
    if (!st_reg.mode_taken) begin
      st_next.mode_taken = 1'h1;
      st_next.fwft = ~timing_mode_select; // [R6]
    end

    // Port A read path
    if (a_pop) begin
      st_next.a_stage = b_to_a_queue.out_data;
      st_next.a_stage_valid = st_reg.fwft;
    end else if (a_rd_queue && st_reg.fwft) begin
      st_next.a_stage_valid = 1'h0;
    end
    if (a_rd_queue) begin
      st_next.a_view_mail = 1'h0;
    end else if (a_rd) begin
      st_next.a_view_mail = 1'h1; // [R18]
      st_next.a_mail_out = st_reg.mail_b2a;
      st_next.mail_b2a_n = 1'h1;
    end

    // Port B read path
    if (b_pop) begin
      st_next.b_stage = a_to_b_queue.out_data;
      st_next.b_stage_valid = st_reg.fwft;
    end else if (b_rd_queue && st_reg.fwft) begin
      st_next.b_stage_valid = 1'h0;
    end
    if (b_rd_queue) begin
      st_next.b_view_mail = 1'h0;
    end else if (b_rd) begin
      st_next.b_view_mail = 1'h1;
      st_next.b_mail_out = st_reg.mail_a2b;
      st_next.mail_a2b_n = 1'h1;
    end

    // Mailbox writes, refused while a word still waits; set wins over clear
    if (a_wr && porta_mailbox_select && st_reg.mail_a2b_n) begin
      st_next.mail_a2b = porta_data_in; // [R18]
      st_next.mail_a2b_n = 1'h0;
    end
    if (b_wr && portb_mailbox_select && st_reg.mail_b2a_n) begin
      st_next.mail_b2a = portb_data_in;
      st_next.mail_b2a_n = 1'h0;
    end

    // Port A flags move only on its clock rise
    if (a_rise && st_reg.mode_taken) begin
      if (st_reg.fwft) begin
        st_next.a_eor = st_reg.a_stage_valid; // [R13]
      end else begin
        st_next.a_eor = b_to_a_queue.out_valid; // [R13] [R19]
      end
      st_next.a_fos = a_to_b_queue.in_ready; // [R15] [R19]
      st_next.a_ae = ~bfq_at_or_below(a_occ, b2a_empty_offset); // [R1] [R19]
      st_next.a_af = ~bfq_at_or_below(a2b_free, a2b_full_offset); // [R3] [R19]
    end

    // Port B flags move only on its clock rise
    if (b_rise && st_reg.mode_taken) begin
      if (st_reg.fwft) begin
        st_next.b_eor = st_reg.b_stage_valid; // [R14]
      end else begin
        st_next.b_eor = a_to_b_queue.out_valid; // [R14] [R19]
      end
      st_next.b_fos = b_to_a_queue.in_ready; // [R16] [R19]
      st_next.b_ae = ~bfq_at_or_below(b_occ, a2b_empty_offset); // [R2] [R19]
      st_next.b_af = ~bfq_at_or_below(b2a_free, b2a_full_offset); // [R4] [R19]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Data pins driven only while selected for reading
  assign porta_data_oe = ~porta_select_n & ~porta_direction; // [R11] [R5]
  assign portb_data_oe = ~portb_select_n & portb_direction; // [R11] [R5]
  assign porta_data_out = st_reg.a_view_mail ? st_reg.a_mail_out : st_reg.a_stage;
  assign portb_data_out = st_reg.b_view_mail ? st_reg.b_mail_out : st_reg.b_stage;

  assign porta_empty_or_ready = st_reg.a_eor;
  assign porta_full_or_space = st_reg.a_fos;
  assign porta_almost_empty = st_reg.a_ae;
  assign porta_almost_full = st_reg.a_af;
  assign portb_empty_or_ready = st_reg.b_eor;
  assign portb_full_or_space = st_reg.b_fos;
  assign portb_almost_empty = st_reg.b_ae;
  assign portb_almost_full = st_reg.b_af;
  assign mail_a2b_flag_n = st_reg.mail_a2b_n;
  assign mail_b2a_flag_n = st_reg.mail_b2a_n;
endmodule : bfq_bidir_port

// ### tb/bfq_bidir_port_asserts.sv
/*
  Checker for the two-way queue port block: drive enables, flag timing, mailbox.
  Assumes port clocks are held low during reset; bound to bfq_bidir_port below.
*/
module bfq_bidir_port_asserts (
  // Clock, reset, mode
  input wire logic mclk,
  input wire logic rst,
  input wire logic timing_mode_select,
  // Port A
  input wire logic porta_clock,
  input wire logic porta_select_n,
  input wire logic porta_enable,
  input wire logic porta_direction,
  input wire logic porta_mailbox_select,
  input wire logic [bfq_pkg::DATA_W-1:0] porta_data_out,
  input wire logic porta_data_oe,
  input wire logic porta_empty_or_ready,
  input wire logic porta_full_or_space,
  input wire logic porta_almost_empty,
  input wire logic porta_almost_full,
  // Port B
  input wire logic portb_clock,
  input wire logic portb_select_n,
  input wire logic portb_enable,
  input wire logic portb_direction,
  input wire logic portb_mailbox_select,
  input wire logic [bfq_pkg::DATA_W-1:0] portb_data_in,
  input wire logic portb_data_oe,
  input wire logic portb_empty_or_ready,
  input wire logic portb_full_or_space,
  input wire logic portb_almost_empty,
  input wire logic portb_almost_full,
  // Mailbox flags
  input wire logic mail_a2b_flag_n,
  input wire logic mail_b2a_flag_n
);
  import bfq_pkg::*;
  logic prev_a_reg;
  logic prev_b_reg;
  logic [DATA_W-1:0] mail_b2a_reg;
  logic rise_a;
  logic rise_b;
  logic take_a;
  logic take_b;
  assign rise_a = porta_clock & ~prev_a_reg;
  assign rise_b = portb_clock & ~prev_b_reg;
  assign take_a = rise_a & ~porta_select_n & porta_enable;
  assign take_b = rise_b & ~portb_select_n & portb_enable;
  // Copy of the B-to-A mailbox word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_a_reg <= 1'h0;
      prev_b_reg <= 1'h0;
      mail_b2a_reg <= RST_WORD;
    end else begin
      prev_a_reg <= porta_clock;
      prev_b_reg <= portb_clock;
      if (take_b && !portb_direction && portb_mailbox_select && mail_b2a_flag_n) begin
        mail_b2a_reg <= portb_data_in;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_mail_wr_a;
    take_a && porta_direction && porta_mailbox_select && mail_a2b_flag_n;
  endsequence
  sequence s_mail_rd_b;
    take_b && portb_direction && portb_mailbox_select;
  endsequence
  AST_OE_A: assert property (porta_data_oe == (!porta_select_n && !porta_direction))
    else $error("port A drive enable wrong");
  AST_OE_B: assert property (portb_data_oe == (!portb_select_n && portb_direction))
    else $error("port B drive enable wrong");
  AST_HOLD_A: assert property (!rise_a |=> $stable({porta_empty_or_ready,
    porta_full_or_space, porta_almost_empty, porta_almost_full}))
    else $error("port A flag moved without port clock rise");
  AST_HOLD_B: assert property (!rise_b |=> $stable({portb_empty_or_ready,
    portb_full_or_space, portb_almost_empty, portb_almost_full}))
    else $error("port B flag moved without port clock rise");
  AST_AE_A: assert property (timing_mode_select && !porta_empty_or_ready |-> !porta_almost_empty)
    else $error("port A almost empty high on empty queue");
  AST_AE_B: assert property (timing_mode_select && !portb_empty_or_ready |-> !portb_almost_empty)
    else $error("port B almost empty high on empty queue");
  AST_MAIL_SET: assert property (s_mail_wr_a |=> !mail_a2b_flag_n)
    else $error("mailbox write did not set flag");
  AST_MAIL_CLR: assert property (s_mail_rd_b |=> mail_a2b_flag_n)
    else $error("mailbox read did not clear flag");
  AST_MAIL_KEEP: assert property (!take_a && !take_b |=>
    $stable({mail_a2b_flag_n, mail_b2a_flag_n}))
    else $error("mailbox flag moved without transfer");
  AST_MAIL_DATA: assert property (take_a && !porta_direction && porta_mailbox_select
    && !mail_b2a_flag_n |-> ##[1:2] porta_data_out == mail_b2a_reg)
    else $error("port A mailbox read data wrong");
endmodule : bfq_bidir_port_asserts

bind bfq_bidir_port bfq_bidir_port_asserts u_asserts (.mclk, .rst, .timing_mode_select,
  .porta_clock, .porta_select_n, .porta_enable, .porta_direction, .porta_mailbox_select,
  .porta_data_out, .porta_data_oe, .porta_empty_or_ready, .porta_full_or_space,
  .porta_almost_empty, .porta_almost_full, .portb_clock, .portb_select_n, .portb_enable,
  .portb_direction, .portb_mailbox_select, .portb_data_in, .portb_data_oe,
  .portb_empty_or_ready, .portb_full_or_space, .portb_almost_empty, .portb_almost_full,
  .mail_a2b_flag_n, .mail_b2a_flag_n);

// ### tb/bfq_port_ctrl.sv
/*
  Bus controller model for one port: continuous port clock, single transfers.
  Assumes the block's mclk and rst; WR_LVL is the direction level that writes.
*/
module bfq_port_ctrl #(
  parameter logic WR_LVL = 1'h1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Port pins
  output logic port_clock,
  output logic select_n,
  output logic enable,
  output logic direction,
  output logic mailbox_select,
  output logic [bfq_pkg::DATA_W-1:0] data_in,
  input wire logic [bfq_pkg::DATA_W-1:0] data_out
);
  import bfq_pkg::*;
  initial begin
    select_n = 1'h1;
    enable = 1'h0;
    direction = ~WR_LVL;
    mailbox_select = 1'h0;
    data_in = RST_WORD;
  end
  // High one cycle, low one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_clock <= 1'h0;
    end else begin
      port_clock <= ~port_clock;
    end
  end
  // Controls set on the mclk edge that raises the port clock, held until it is sampled
  task automatic xfer(input logic wr, input logic mb, input logic sel_n, input logic en,
      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    @(posedge mclk);
    if (port_clock) begin
      @(posedge mclk);
    end
    select_n <= sel_n;
    enable <= en;
    direction <= wr ? WR_LVL : ~WR_LVL;
    mailbox_select <= mb;
    data_in <= wd;
    @(posedge mclk);
    select_n <= 1'h1;
    enable <= 1'h0;
    data_in <= ~wd;
    repeat (2) @(posedge mclk);
    #1;
    rd = data_out;
  endtask : xfer
endmodule : bfq_port_ctrl

// ### tb/tb.sv
/*
  Self-checking bench for the two-way queue port block.
  Assumes the checker binds itself; one controller model drives each port.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bfq_pkg::*;
  logic mclk, rst, timing_mode_select, mail_a2b_flag_n, mail_b2a_flag_n;
  logic [CNT_W-1:0] a2b_empty_offset, b2a_empty_offset, a2b_full_offset, b2a_full_offset;
  logic porta_clock, porta_select_n, porta_enable, porta_direction, porta_mailbox_select;
  logic porta_data_oe, porta_empty_or_ready, porta_full_or_space, porta_almost_empty;
  logic portb_clock, portb_select_n, portb_enable, portb_direction, portb_mailbox_select;
  logic portb_data_oe, portb_empty_or_ready, portb_full_or_space, portb_almost_empty;
  logic porta_almost_full, portb_almost_full;
  logic [DATA_W-1:0] porta_data_in, porta_data_out, portb_data_in, portb_data_out, rd;
  int err_count, n_compared;

  bfq_bidir_port DUT (.mclk, .rst, .timing_mode_select, .porta_clock, .porta_select_n,
    .porta_enable, .porta_direction, .porta_mailbox_select, .porta_data_in, .porta_data_out,
    .porta_data_oe, .porta_empty_or_ready, .porta_full_or_space, .porta_almost_empty,
    .porta_almost_full, .portb_clock, .portb_select_n, .portb_enable, .portb_direction,
    .portb_mailbox_select, .portb_data_in, .portb_data_out, .portb_data_oe,
    .portb_empty_or_ready, .portb_full_or_space, .portb_almost_empty, .portb_almost_full,
    .a2b_empty_offset, .b2a_empty_offset, .a2b_full_offset, .b2a_full_offset,
    .mail_a2b_flag_n, .mail_b2a_flag_n);
  bfq_port_ctrl #(.WR_LVL(1'h1)) PA (.mclk, .rst, .port_clock(porta_clock),
    .select_n(porta_select_n), .enable(porta_enable), .direction(porta_direction),
    .mailbox_select(porta_mailbox_select), .data_in(porta_data_in), .data_out(porta_data_out));
  bfq_port_ctrl #(.WR_LVL(1'h0)) PB (.mclk, .rst, .port_clock(portb_clock),
    .select_n(portb_select_n), .enable(portb_enable), .direction(portb_direction),
    .mailbox_select(portb_mailbox_select), .data_in(portb_data_in), .data_out(portb_data_out));

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [3:0] fa();
    return {porta_empty_or_ready, porta_full_or_space, porta_almost_empty, porta_almost_full};
  endfunction : fa
  function automatic logic [3:0] fb();
    return {portb_empty_or_ready, portb_full_or_space, portb_almost_empty, portb_almost_full};
  endfunction : fb
  function automatic logic [3:0] fm();
    return {2'h0, mail_a2b_flag_n, mail_b2a_flag_n};
  endfunction : fm

  task automatic chk_w(input string what, input logic [DATA_W-1:0] exp,
      input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_w
  task automatic chk_f(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_f
  task automatic idle(input int n);
    repeat (2 * n) @(posedge mclk);
    #1;
  endtask : idle
  task automatic do_reset(input logic m);
    @(posedge mclk);
    rst <= 1'h1;
    timing_mode_select <= m;
    repeat (2) @(posedge mclk);
    #1;
    chk_f("a_flags", {RST_EMPTY_OR_READY, RST_FULL_OR_SPACE, RST_ALMOST_EMPTY, RST_ALMOST_FULL},
      fa());
    chk_f("mail", {2'h0, RST_MAIL_FLAG_N, RST_MAIL_FLAG_N}, fm());
    @(posedge mclk);
    rst <= 1'h0;
    idle(1);
  endtask : do_reset

  // Fill A-to-B past full, drain in order; almost flags at their offsets
  task automatic t_a2b;
    for (int i = 0; i < 9; i++) begin
      PA.xfer(1'h1, 1'h0, 1'h0, 1'h1, {4'h8, 32'(i)}, rd);
      idle(2);
      chk_f("a_flags", {1'h0, i < 7, 1'h0, (7 - i) > 2}, fa());
      chk_f("b_flags", {1'h1, 1'h1, i > 1, 1'h1}, fb());
    end
    for (int i = 0; i < 8; i++) begin
      PB.xfer(1'h0, 1'h0, 1'h0, 1'h1, 36'h0, rd);
      chk_w("b_read", {4'h8, 32'(i)}, rd);
      idle(2);
      chk_f("b_flags", {i < 7, 1'h1, (7 - i) > 2, 1'h1}, fb());
    end
    $display("t_a2b done");
  endtask : t_a2b
  // Deselected and disabled writes are ignored; B-to-A word read at A
  task automatic t_b2a;
    PB.xfer(1'h1, 1'h0, 1'h1, 1'h1, 36'h1_2345_6789, rd);
    PB.xfer(1'h1, 1'h0, 1'h0, 1'h0, 36'h2_3456_789a, rd);
    PB.xfer(1'h1, 1'h0, 1'h0, 1'h1, 36'hf_edcb_a987, rd);
    idle(2);
    chk_f("a_flags", 4'hf, fa());
    chk_f("b_flags", 4'h4, fb());
    PA.xfer(1'h0, 1'h0, 1'h0, 1'h1, 36'h0, rd);
    chk_w("a_read", 36'hf_edcb_a987, rd);
    idle(2);
    chk_f("a_flags", 4'h5, fa());
    chk_f("b_flags", 4'h5, fb());
    $display("t_b2a done");
  endtask : t_b2a
  // Mailbox both ways; second write while full is dropped
  task automatic t_mail;
    PA.xfer(1'h1, 1'h1, 1'h0, 1'h1, 36'ha_aaaa_0001, rd);
    PA.xfer(1'h1, 1'h1, 1'h0, 1'h1, 36'h5_5555_0002, rd);
    chk_f("mail", 4'h1, fm());
    PB.xfer(1'h0, 1'h1, 1'h0, 1'h1, 36'h0, rd);
    chk_w("b_mail", 36'ha_aaaa_0001, rd);
    PB.xfer(1'h1, 1'h1, 1'h0, 1'h1, 36'h3_c3c3_0003, rd);
    chk_f("mail", 4'h2, fm());
    PA.xfer(1'h0, 1'h1, 1'h0, 1'h1, 36'h0, rd);
    chk_w("a_mail", 36'h3_c3c3_0003, rd);
    chk_f("mail", 4'h3, fm());
    $display("t_mail done");
  endtask : t_mail
  // Fall-through: word shows at B without a read
  task automatic t_fwft;
    do_reset(1'h0);
    PA.xfer(1'h1, 1'h0, 1'h0, 1'h1, 36'h9_0f0f_0f0f, rd);
    idle(3);
    chk_w("b_fall", 36'h9_0f0f_0f0f, portb_data_out);
    chk_f("b_flags", 4'hd, fb());
    PB.xfer(1'h0, 1'h0, 1'h0, 1'h1, 36'h0, rd);
    idle(2);
    chk_f("b_flags", 4'h5, fb());
    chk_f("a_flags", 4'h5, fa());
    $display("t_fwft done");
  endtask : t_fwft

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    err_count = 0;
    n_compared = 0;
    rst = 1'h1;
    timing_mode_select = 1'h1;
    a2b_empty_offset = 4'h2;
    b2a_empty_offset = 4'h0;
    a2b_full_offset = 4'h2;
    b2a_full_offset = 4'h7;
    do_reset(1'h1);
    t_a2b();
    t_b2a();
    t_mail();
    t_fwft();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule : tb
